// >>> sfp_flash_end.sv
// Purpose: status word, write latch and command gating of the flash end
// Assumes: link pins asynchronous, oversampled by sys_clk
// Notes: array itself is outside; it sees staged bytes and commits
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_end (
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_n_i,
    // serial link
    sfp_link_if.flash                 link,
    // array side
    input  wire logic [15:0]          nv_init_i,
    input  wire logic                 addr_protected_i,
    output logic                      op_start_o,
    output sfp_pkg::sfp_op_type       op_kind_o,
    output logic [23:0]               op_addr_o,
    output logic [7:0]                prog_byte_o,
    output logic                      prog_valid_o,
    output logic [23:0]               frame_addr_o,
    output logic [15:0]               status_o,
    output logic                      quad_lines_o,
    output logic                      security_locked_o,
    output logic                      deep_down_o
);
    import sfp_pkg::*;

    typedef struct packed {
        logic [3:0]        sync1;
        logic [3:0]        sync2;
        logic              cs_prev;
        logic              sck_prev;
        logic              loaded;
        logic [2:0]        bit_cnt;
        logic [7:0]        byte_cnt;
        logic [7:0]        shift;
        logic [7:0]        opcode;
        logic [23:0]       addr;
        logic [15:0]       nv;
        logic              latch;
        logic              susp;
        logic              deep;
        logic [BUSY_W-1:0] busy_cnt;
        logic [7:0]        out_shift;
        logic              miso;
        logic              op_start;
        sfp_op_type        op_kind;
        logic [23:0]       op_addr;
        logic [7:0]        prog_byte;
        logic              prog_valid;
        logic [15:0]       status;
    } sfp_dev_type;

    localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY_CYC);

    sfp_dev_type q;
    sfp_dev_type d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       cs;
        logic       sck;
        logic       sdi;
        logic       wpn;
        logic       rise;
        logic       fall;
        logic       pend;
        logic       aligned;
        logic       ok_wr;
        logic       sr_ok;
        logic       reading;
        logic [7:0] sh;
        logic [7:0] op_now;
        logic [15:0] wr_word;
        cs      = 1'b0;
        sck     = 1'b0;
        sdi     = 1'b0;
        wpn     = 1'b0;
        rise    = 1'b0;
        fall    = 1'b0;
        pend    = 1'b0;
        aligned = 1'b0;
        ok_wr   = 1'b0;
        sr_ok   = 1'b0;
        reading = 1'b0;
        sh      = 8'h00;
        op_now  = 8'h00;
        wr_word = 16'h0000;

        d = q;
        d.op_start   = 1'b0;
        d.prog_valid = 1'b0;
        d.sync1      = {link.cs_n, link.sclk, link.mosi, link.wp_n};
        d.sync2      = q.sync1;
        cs  = q.sync2[3];
        sck = q.sync2[2];
        sdi = q.sync2[1];
        wpn = q.sync2[0];
        d.cs_prev  = cs;
        d.sck_prev = sck;
        rise = sck & ~q.sck_prev & ~cs;
        fall = ~sck & q.sck_prev & ~cs;
        pend = (q.busy_cnt != '0);

        // stored word is caught once after release; power lock drops
        if (!q.loaded) begin
            d.loaded = 1'b1;
            d.nv     = nv_init_i & NV_MASK;
            if (d.nv[SB_LOCK1:SB_LOCK0] == LOCK_POWER) begin
                d.nv[SB_LOCK1:SB_LOCK0] = LOCK_SOFT;
            end
        end

        // suspended work holds its remaining time
        if (pend && !q.susp) begin
            d.busy_cnt = q.busy_cnt - 1'b1;
        end

        reading = (q.byte_cnt != 8'h00) && !q.deep &&
                  ((q.opcode == OP_STAT_RD_LO) ||
                   (q.opcode == OP_STAT_RD_HI));

        if (rise) begin
            sh = {q.shift[6:0], sdi};
            d.shift   = sh;
            d.bit_cnt = q.bit_cnt + 1'b1;
            if (q.bit_cnt == BIT_LAST) begin
                if (q.byte_cnt != BYTE_CNT_MAX) begin
                    d.byte_cnt = q.byte_cnt + 1'b1;
                end
                op_now = (q.byte_cnt == 8'h00) ? sh : q.opcode;
                if (q.byte_cnt == 8'h00) begin
                    d.opcode = sh;
                end else if (q.byte_cnt <= LEN_ADDR_END) begin
                    d.addr = {q.addr[15:0], sh};
                end else if (q.opcode == OP_PAGE_PROG && q.latch &&
                             !pend && !q.deep) begin
                    d.prog_byte  = sh;
                    d.prog_valid = 1'b1;
                end
                if (!q.deep && ((op_now == OP_STAT_RD_LO) ||
                                (op_now == OP_STAT_RD_HI))) begin
                    // reload each byte so polling sees live busy
                    d.out_shift = (op_now == OP_STAT_RD_LO) ?
                                  q.status[7:0] : q.status[15:8];
                end
            end
        end

        if (fall && reading) begin
            d.miso      = q.out_shift[7];
            d.out_shift = {q.out_shift[6:0], 1'b0};
        end

        if (cs) begin
            d.bit_cnt  = 3'h0;
            d.byte_cnt = 8'h00;
            d.miso     = 1'b0;
        end

        ////////////////////////////////////////////////////////////////
        // commands act on deselect only
        aligned = (q.bit_cnt == 3'h0) && (q.byte_cnt != 8'h00);
        ok_wr   = aligned && q.latch && !pend && !q.deep;
        unique case (q.nv[SB_LOCK1:SB_LOCK0])
            LOCK_SOFT: sr_ok = 1'b1;
            LOCK_HW:   sr_ok = q.nv[SB_QUAD] | wpn;
            default:   sr_ok = 1'b0;
        endcase
        wr_word = {q.addr[7:0], q.addr[15:8]};

        if (cs && !q.cs_prev && q.loaded) begin
            if (q.deep) begin
                if (q.opcode == OP_DEEP_WAKE && q.byte_cnt != 8'h00) begin
                    d.deep = 1'b0;
                end
            end else if (q.opcode == OP_LATCH_SET) begin
                if (aligned && !pend) d.latch = 1'b1;
            end else if (q.opcode == OP_LATCH_CLR) begin
                if (aligned && !pend) d.latch = 1'b0;
            end else if (q.opcode == OP_STAT_WRITE) begin
                if (ok_wr && sr_ok && q.byte_cnt >= LEN_STAT_WRITE) begin
                    d.nv = (wr_word & NV_MASK) | (q.nv & SECLK_MASK);
                    d.latch    = 1'b0;
                    d.busy_cnt = BUSY_LOAD;
                    d.op_start = 1'b1;
                    d.op_kind  = SFP_OP_STATUS;
                end
            end else if (q.opcode == OP_PAGE_PROG) begin
                // partial byte leaves aligned low: latch kept
                if (ok_wr && q.byte_cnt >= LEN_PROG_MIN &&
                    !addr_protected_i) begin
                    d.latch    = 1'b0;
                    d.busy_cnt = BUSY_LOAD;
                    d.op_start = 1'b1;
                    d.op_kind  = SFP_OP_PROGRAM;
                    d.op_addr  = q.addr;
                end
            end else if (q.opcode == OP_SECT_ERASE ||
                         q.opcode == OP_BLK_ERASE32 ||
                         q.opcode == OP_BLK_ERASE64) begin
                if (ok_wr && q.byte_cnt >= LEN_ERASE &&
                    !addr_protected_i) begin
                    d.latch    = 1'b0;
                    d.busy_cnt = BUSY_LOAD;
                    d.op_start = 1'b1;
                    d.op_addr  = q.addr;
                    d.op_kind  = (q.opcode == OP_SECT_ERASE) ? SFP_OP_SECTOR :
                                 (q.opcode == OP_BLK_ERASE32) ?
                                 SFP_OP_BLOCK32 : SFP_OP_BLOCK64;
                end
            end else if (q.opcode == OP_CHIP_ERASEA ||
                         q.opcode == OP_CHIP_ERASEB) begin
                if (ok_wr &&
                    ((q.nv[SB_BP_LO+2:SB_BP_LO] == BP_LOW_ZERO &&
                      !q.nv[SB_CMP]) ||
                     (q.nv[SB_BP_LO+2:SB_BP_LO] == BP_LOW_ONES &&
                      q.nv[SB_CMP]))) begin
                    d.latch    = 1'b0;
                    d.busy_cnt = BUSY_LOAD;
                    d.op_start = 1'b1;
                    d.op_kind  = SFP_OP_CHIP;
                    d.op_addr  = 24'h000000;
                end
            end else if (q.opcode == OP_SUSPEND) begin
                d.susp = 1'b1;
            end else if (q.opcode == OP_RESUME) begin
                d.susp = 1'b0;
            end else if (q.opcode == OP_DEEP_DOWN) begin
                if (aligned && !pend) d.deep = 1'b1;
            end
        end

        d.status = d.nv & NV_MASK;
        d.status[SB_BUSY]  = (d.busy_cnt != '0) && !d.susp;
        d.status[SB_LATCH] = d.latch;
        d.status[SB_SUSP]  = d.susp;
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
            q.sync1  <= 4'hf;
            q.sync2  <= 4'hf;
            q.cs_prev <= 1'b1;
            q.nv     <= STATUS_RESET;
            q.status <= STATUS_RESET;
        end else begin
            q <= d;
        end
    end

    assign link.miso         = q.miso;
    assign op_start_o        = q.op_start;
    assign op_kind_o         = q.op_kind;
    assign op_addr_o         = q.op_addr;
    assign prog_byte_o       = q.prog_byte;
    assign prog_valid_o      = q.prog_valid;
    assign frame_addr_o      = q.addr;
    assign status_o          = q.status;
    assign quad_lines_o      = q.nv[SB_QUAD];
    assign security_locked_o = q.nv[SB_SECLK];
    assign deep_down_o       = q.deep;
endmodule : sfp_flash_end
`default_nettype wire

// >>> sfp_pkg.sv
// Purpose: shared constants and types for the flash status/protect link
// Assumes: mode-0 style serial link, clock idle low, msb first
// Notes: opcodes, status bit positions and link timing live here
// Functional notes
// - busy flag high while unsuspended program/erase/status write
// - latch clear refuses status write, program, erase
// - protect field guards program, sector, block erase
// - protect bits change only outside hardware protect
// - chip erase needs bits2..0 all matching complement
// - lock mode 00: write allowed when latch set
// - lock mode 01, protect pin low: locked
// - lock mode 01, protect pin high: writable
// - lock mode 10 locks until power cycle
// - lock mode 11 locks status word forever
// - quad enable turns protect pin into data
// - security lock bit sets once, never clears
// - complement bit joins protect field, default zero
// - suspend flag set by 75h, cleared 7ah
// - msb first, bits sampled on rising clock
// - frame opens with one opcode byte
// - host deselects after final bit sent
// - reads stream until host deselects
// - write-type commands need byte-aligned deselect
// - partial program byte: nothing, latch stays
// - latch set by 06h, cleared by writes
package sfp_pkg;
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int SCLK_PERIOD_NS    = 160;
    localparam int SCLK_HALF_CYC     =
        (SCLK_PERIOD_NS / 2 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int BUSY_TIME_NS      = 2000;
    localparam int BUSY_CYC          = BUSY_TIME_NS / SYS_CLK_PERIOD_NS;
    localparam int BUSY_W            = 8;
    localparam int DIV_W             = 8;

    localparam logic [7:0] OP_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR   = 8'h04;
    localparam logic [7:0] OP_STAT_RD_LO  = 8'h05;
    localparam logic [7:0] OP_STAT_RD_HI  = 8'h35;
    localparam logic [7:0] OP_STAT_WRITE  = 8'h01;
    localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
    localparam logic [7:0] OP_SECT_ERASE  = 8'h20;
    localparam logic [7:0] OP_BLK_ERASE32 = 8'h52;
    localparam logic [7:0] OP_BLK_ERASE64 = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASEA = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASEB = 8'hc7;
    localparam logic [7:0] OP_SUSPEND     = 8'h75;
    localparam logic [7:0] OP_RESUME      = 8'h7a;
    localparam logic [7:0] OP_DEEP_DOWN   = 8'hb9;
    localparam logic [7:0] OP_DEEP_WAKE   = 8'hab;

    // frame lengths in bytes, opcode included
    localparam logic [7:0] LEN_STAT_WRITE = 8'h03;
    localparam logic [7:0] LEN_ERASE      = 8'h04;
    localparam logic [7:0] LEN_PROG_MIN   = 8'h05;
    localparam logic [7:0] LEN_ADDR_END   = 8'h03;
    localparam logic [7:0] BYTE_CNT_MAX   = 8'hff;
    localparam logic [2:0] BIT_LAST       = 3'h7;

    localparam int SB_BUSY  = 0;
    localparam int SB_LATCH = 1;
    localparam int SB_BP_LO = 2;
    localparam int SB_LOCK0 = 7;
    localparam int SB_LOCK1 = 8;
    localparam int SB_QUAD  = 9;
    localparam int SB_SECLK = 10;
    localparam int SB_CMP   = 14;
    localparam int SB_SUSP  = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] NV_MASK      = 16'h47fc;
    localparam logic [15:0] SECLK_MASK   = 16'h0400;
    localparam logic [2:0]  BP_LOW_ZERO  = 3'h0;
    localparam logic [2:0]  BP_LOW_ONES  = 3'h7;
    localparam logic [1:0]  LOCK_SOFT    = 2'h0;
    localparam logic [1:0]  LOCK_HW      = 2'h1;
    localparam logic [1:0]  LOCK_POWER   = 2'h2;

    typedef enum logic [2:0] {
        SFP_OP_NONE    = 3'b000,
        SFP_OP_PROGRAM = 3'b001,
        SFP_OP_SECTOR  = 3'b010,
        SFP_OP_BLOCK32 = 3'b011,
        SFP_OP_BLOCK64 = 3'b100,
        SFP_OP_CHIP    = 3'b101,
        SFP_OP_STATUS  = 3'b110
    } sfp_op_type;
endpackage : sfp_pkg

// >>> sfp_link_if.sv
// Purpose: serial link wires between host controller and flash end
// Assumes: all wires single driver, no turnaround lines
// Notes: quad data lines are not carried
`timescale 1ns/1ps
`default_nettype none
interface sfp_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic wp_n;
    modport host  (output cs_n, output sclk, output mosi, output wp_n,
                   input miso);
    modport flash (input cs_n, input sclk, input mosi, input wp_n,
                   output miso);
endinterface : sfp_link_if
`default_nettype wire

// >>> sfp_host_end.sv
// Purpose: host serial controller framing one command per request
// Assumes: opcode plus up to four sent and four received bytes
// Notes: extra bits allow deliberately misaligned deselect
`timescale 1ns/1ps
`default_nettype none
module sfp_host_end (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    // serial link
    sfp_link_if.host         link,
    // request side
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic [7:0]  req_opcode_i,
    input  wire logic [31:0] req_data_i,
    input  wire logic [2:0]  req_tx_len_i,
    input  wire logic [2:0]  req_rx_len_i,
    input  wire logic [2:0]  req_extra_bits_i,
    input  wire logic        wp_level_i,
    // answer side
    output logic [31:0]      rx_data_o,
    output logic             done_o
);
    import sfp_pkg::*;

    typedef enum logic [1:0] {
        SFP_H_IDLE   = 2'b00,
        SFP_H_SELECT = 2'b01,
        SFP_H_SHIFT  = 2'b10,
        SFP_H_FINISH = 2'b11
    } sfp_hstate_type;

    typedef struct packed {
        sfp_hstate_type state;
        logic [DIV_W-1:0] div;
        logic           sclk;
        logic           cs_n;
        logic           mosi;
        logic           wp_n;
        logic [39:0]    tx;
        logic [6:0]     bits_left;
        logic [31:0]    rx;
        logic [1:0]     miso_sync;
        logic           done;
    } sfp_host_type;

    localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(SCLK_HALF_CYC - 1);

    sfp_host_type q;
    sfp_host_type d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic half_done;
        half_done = (q.div == HALF_LAST);
        d = q;
        d.done      = 1'b0;
        d.wp_n      = wp_level_i;
        d.miso_sync = {q.miso_sync[0], link.miso};
        d.div       = half_done ? '0 : q.div + 1'b1;
        unique case (q.state)
            SFP_H_IDLE: begin
                d.div = '0;
                if (req_valid_i) begin
                    d.state = SFP_H_SELECT;
                    d.cs_n  = 1'b0;
                    d.tx    = {req_opcode_i, req_data_i};
                    d.mosi  = req_opcode_i[7];
                    d.rx    = 32'h00000000;
                    d.bits_left = {1'b0, req_tx_len_i, 3'h0} +
                                  {1'b0, req_rx_len_i, 3'h0} +
                                  {4'h0, req_extra_bits_i} + 7'h08;
                end
            end
            SFP_H_SELECT: begin
                if (half_done) d.state = SFP_H_SHIFT;
            end
            SFP_H_SHIFT: begin
                if (half_done && !q.sclk) begin
                    d.sclk = 1'b1;
                    d.rx   = {q.rx[30:0], q.miso_sync[1]};
                    d.bits_left = q.bits_left - 1'b1;
                end else if (half_done) begin
                    d.sclk = 1'b0;
                    d.tx   = {q.tx[38:0], 1'b0};
                    d.mosi = q.tx[38];
                    if (q.bits_left == 7'h00) d.state = SFP_H_FINISH;
                end
            end
            SFP_H_FINISH: begin
                if (half_done) begin
                    d.cs_n  = 1'b1;
                    d.mosi  = 1'b0;
                    d.done  = 1'b1;
                    d.state = SFP_H_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
            q.state <= SFP_H_IDLE;
            q.cs_n  <= 1'b1;
            q.wp_n  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign req_ready_o = (q.state == SFP_H_IDLE);
    assign link.cs_n   = q.cs_n;
    assign link.sclk   = q.sclk;
    assign link.mosi   = q.mosi;
    assign link.wp_n   = q.wp_n;
    assign rx_data_o   = q.rx;
    assign done_o      = q.done;
endmodule : sfp_host_end
`default_nettype wire

// >>> sfp_link_asserts.sv
// Purpose: protocol checks on the serial link between both ends
// Assumes: both ends on sys_clk_i, host half period of 10 cycles
// Notes: wires only; array side is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module sfp_link_asserts (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_n_i,
    // link wires
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic wp_n
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////
    sequence high_half_s;
        sclk [*8] ##1 sclk ##1 sclk;
    endsequence
    sequence first_rise_s;
        ##[1:30] $rose(sclk);
    endsequence

    idle_clock_low_a: assert property (cs_n |-> !sclk)
        else $error("link clock high while deselected");
    high_half_a: assert property ($rose(sclk) |-> high_half_s ##1 !sclk)
        else $error("link clock high phase not ten cycles");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data moved while clock high");
    select_hold_a: assert property (sclk |-> !cs_n)
        else $error("select raised with clock high");
    first_edge_a: assert property ($fell(cs_n) |-> first_rise_s)
        else $error("no clock rise soon after select");
    deselect_bound_a: assert property ($fell(sclk) |-> ##[1:14] (sclk || cs_n))
        else $error("frame stalled after a clock fall");
    miso_quiet_a: assert property (cs_n [*8] |-> !miso)
        else $error("flash drives data while deselected");
    miso_hold_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(miso))
        else $error("flash data moved while clock high");
    frame_gap_a: assert property ($rose(cs_n) |=> cs_n)
        else $error("no idle cycle between frames");
endmodule : sfp_link_asserts
`default_nettype wire

// >>> sfp_tb_top.sv
// Purpose: host and flash ends joined, checked against a status model
// Assumes: one frame at a time, busy waited out before the next
// Notes: suspend tried only while idle, so busy freeze is unseen
`timescale 1ns/1ps
`default_nettype none
module sfp_tb_top;
    import sfp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        vld = 1'b0;
    logic        rdy;
    logic        done;
    logic        wp = 1'b1;
    logic        prot = 1'b0;
    logic        start;
    logic        quad;
    logic        seclk;
    logic        deep;
    logic [2:0]  kind;
    logic [2:0]  ek = 3'h0;
    logic        dp = 1'b0;
    logic [7:0]  r_op = 8'h00;
    logic [31:0] r_dat = 32'h0;
    logic [2:0]  r_tx = 3'h0;
    logic [2:0]  r_rx = 3'h0;
    logic [2:0]  r_xb = 3'h0;
    logic [31:0] rxd;
    logic [15:0] nv = 16'h0;
    logic [15:0] status;
    int          st;
    int          n_errors;
    int          comparisons;
    int          n_ops;
    int          e_ops;
    int          cyc;
    int          v;

    sfp_link_if link ();
    sfp_host_end i_sfp_host_end (
        .sys_clk_i(clk), .reset_n_i(rst_n), .link(link.host),
        .req_valid_i(vld), .req_ready_o(rdy), .req_opcode_i(r_op),
        .req_data_i(r_dat), .req_tx_len_i(r_tx), .req_rx_len_i(r_rx),
        .req_extra_bits_i(r_xb), .wp_level_i(wp), .rx_data_o(rxd),
        .done_o(done));
    sfp_flash_end i_sfp_flash_end (
        .sys_clk_i(clk), .reset_n_i(rst_n), .link(link.flash),
        .nv_init_i(nv), .addr_protected_i(prot), .op_start_o(start),
        .op_kind_o(kind), .op_addr_o(), .prog_byte_o(), .prog_valid_o(),
        .frame_addr_o(), .status_o(status), .quad_lines_o(quad),
        .security_locked_o(seclk), .deep_down_o(deep));
    sfp_link_asserts i_sfp_link_asserts (
        .sys_clk_i(clk), .reset_n_i(rst_n), .cs_n(link.cs_n),
        .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
        .wp_n(link.wp_n));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (start === 1'b1) n_ops++;
        if (cyc == 60000) begin
            n_errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compares %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend

    // power cycle: lock mode 10 comes back open
    task automatic rst(input logic [15:0] img);
        rst_n <= 1'b0;
        nv <= img;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        st = img & NV_MASK;
        if (st[8:7] == LOCK_POWER) st[8] = 1'b0;
        ek = 3'h0;
        chk(status, st[15:0]);
    endtask : rst

    task automatic fr(input logic [7:0] op, input logic [31:0] d,
                      input logic [2:0] tx, input logic [2:0] rx,
                      input logic [2:0] xb);
        int k;
        r_op <= op;
        r_dat <= d;
        r_tx <= tx;
        r_rx <= rx;
        r_xb <= xb;
        vld <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 9 && rdy !== 1'b1; k++) @(posedge clk);
        vld <= 1'b0;
        for (k = 0; k < 2000 && done !== 1'b1; k++) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask : fr

    task automatic run(input logic [7:0] op, input logic [31:0] d,
                       input logic [2:0] tx, input logic [2:0] xb);
        logic       ok;
        logic [1:0] lm;
        // model reads wp and prot only after they have settled
        fr(op, d, tx, 3'h0, xb);
        ok = xb == 3'h0 && st[SB_LATCH] && !dp;
        lm = st[8:7];
        case (op)
            OP_LATCH_SET: if (xb == 3'h0 && !dp)
                st[SB_LATCH] = 1'b1;
            OP_LATCH_CLR: if (xb == 3'h0 && !dp)
                st[SB_LATCH] = 1'b0;
            OP_STAT_WRITE: if (ok && (lm == LOCK_SOFT || lm == LOCK_HW
                    && (wp || st[SB_QUAD])))
                st = {d[23:16], d[31:24]} & NV_MASK | st & SECLK_MASK | 1;
            OP_SECT_ERASE, OP_PAGE_PROG: if (ok && !prot) st = st & ~2 | 1;
            OP_CHIP_ERASEA, OP_CHIP_ERASEB: if (ok && (st[4:2] == 0
                    && !st[SB_CMP] || st[4:2] == 7 && st[SB_CMP]))
                st = st & ~2 | 1;
            OP_SUSPEND: st[SB_SUSP] = 1'b1;
            OP_RESUME: st[SB_SUSP] = 1'b0;
            OP_DEEP_DOWN: if (xb == 3'h0 && !dp) dp = 1'b1;
            OP_DEEP_WAKE: dp = 1'b0;
            default: ;
        endcase
        if (st[SB_BUSY]) begin
            e_ops++;
            ek = (op == OP_STAT_WRITE) ? SFP_OP_STATUS :
                 (op == OP_PAGE_PROG) ? SFP_OP_PROGRAM :
                 (op == OP_SECT_ERASE) ? SFP_OP_SECTOR : SFP_OP_CHIP;
        end
        chk(status, st[15:0]);
        chk({n_ops[7:0], 5'h0, deep, quad, seclk},
            {e_ops[7:0], 5'h0, dp, st[9], st[10]});
        chk({13'h0, kind}, {13'h0, ek});
        if (st[SB_BUSY]) begin
            repeat (250) @(posedge clk);
            st[SB_BUSY] = 1'b0;
            chk(status, st[15:0]);
        end
    endtask : run

    // a read may stop after any bit: three bits of the next repeat
    task automatic rd();
        fr(OP_STAT_RD_LO, 32'h0, 3'h0, 3'h2, 3'h0);
        chk(rxd[15:0], {st[7:0], st[7:0]});
        fr(OP_STAT_RD_HI, 32'h0, 3'h0, 3'h1, 3'h3);
        chk({5'h0, rxd[10:0]}, {5'h0, st[15:8], st[15:13]});
    endtask : rd
    ////////////////////////////////////////////////////////////
    initial begin
        v = $urandom(23);
        rst(v[15:0] & 16'hff7f);
        tend("reset");
        run(OP_STAT_WRITE, v, 3'h2, 3'h0);
        run(OP_LATCH_SET, 0, 3'h0, 3'h3);
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_STAT_WRITE, 32'h80040000, 3'h2, 3'h0);
        wp <= 1'b0;
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_STAT_WRITE, v, 3'h2, 3'h0);
        wp <= 1'b1;
        run(OP_STAT_WRITE, 32'h80000000, 3'h2, 3'h0);
        tend("lock");
        for (int i = 0; i < 4; i++) begin
            run(OP_LATCH_SET, 0, 3'h0, 3'h0);
            run(OP_STAT_WRITE, {3'h4, {3{i[0]}}, 3'h0, i[1], 22'h0},
                3'h2, 3'h0);
            run(OP_LATCH_SET, 0, 3'h0, 3'h0);
            run(i[0] ? OP_CHIP_ERASEB : OP_CHIP_ERASEA, 0, 3'h0, 3'h0);
        end
        tend("chip");
        prot <= 1'b1;
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_SECT_ERASE, v, 3'h3, 3'h0);
        prot <= 1'b0;
        run(OP_SECT_ERASE, v, 3'h3, 3'h0);
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_PAGE_PROG, v, 3'h4, 3'h4);
        run(OP_PAGE_PROG, v, 3'h4, 3'h0);
        tend("array");
        run(OP_SUSPEND, 0, 3'h0, 3'h0);
        rd();
        run(OP_RESUME, 0, 3'h0, 3'h0);
        rd();
        tend("read");
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_DEEP_DOWN, 0, 3'h0, 3'h5);
        run(OP_DEEP_DOWN, 0, 3'h0, 3'h0);
        run(OP_LATCH_CLR, 0, 3'h0, 3'h0);
        run(OP_DEEP_WAKE, 0, 3'h0, 3'h0);
        run(OP_LATCH_CLR, 0, 3'h0, 3'h0);
        tend("deep");
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_STAT_WRITE, 32'h80020000, 3'h2, 3'h0);
        wp <= 1'b0;
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_STAT_WRITE, 32'h0, 3'h2, 3'h0);
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_STAT_WRITE, 32'h00010000, 3'h2, 3'h0);
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_STAT_WRITE, 32'h0, 3'h2, 3'h0);
        rst(status);
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_STAT_WRITE, 32'h80010000, 3'h2, 3'h0);
        run(OP_LATCH_SET, 0, 3'h0, 3'h0);
        run(OP_STAT_WRITE, 32'h0, 3'h2, 3'h0);
        tend("modes");
        test_done();
    end
endmodule : sfp_tb_top
`default_nettype wire
